// File: rtl/apv_top.sv
// alarm point evaluation and system wide alarm verification
`timescale 1ns/1ps
`default_nettype none
module apv_top
  import apv_pkg::*;
#(
  parameter int CYC_PER_S = APV_CLK_HZ,
  parameter int SUPPLY_RST_S = APV_SUPPLY_RST_S
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cfg_wr,
  input wire logic [APV_PW-1:0] cfg_pt,
  input wire logic [APV_FW-1:0] cfg_func,
  input wire logic [APV_ZW-1:0] cfg_zone,
  input wire logic cfg_open_alarm,
  input wire logic cfg_verify,
  input wire logic cfg_latch,
  input wire logic func_wr,
  input wire logic [APV_FW-1:0] func_idx,
  input wire logic [1:0] func_kind,
  input wire logic [APV_NPTS-1:0] pt_addressable,
  input wire logic [APV_NPTS-1:0] pt_two_wire,
  input wire logic rrr_wr,
  input wire logic [APV_SW-1:0] rrr_secs,
  input wire logic [2*APV_NPTS-1:0] loop_state,
  input wire logic sys_reset,
  output logic [APV_NPTS-1:0] pt_alarm,
  output logic [APV_NPTS-1:0] pt_trouble,
  output logic [APV_ZW-1:0] alarm_zone,
  output logic alarm_zone_vld,
  output logic [APV_NPTS-1:0] slc_reset_cmd,
  output logic detector_supply_output_off,
  output logic zone59_active,
  output logic [APV_ZW-1:0] zone59_num,
  output logic verify_busy,
  output logic [APV_SW-1:0] rrr_secs_q_out
);
  localparam logic [31:0] SUP_CYC = 32'(SUPPLY_RST_S * CYC_PER_S);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2*APV_NPTS-1:0] loop_s1_q, loop_s2_q;
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      loop_s1_q <= '0;
      loop_s2_q <= '0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else if (ce)
    begin
      loop_s1_q <= loop_state;
      loop_s2_q <= loop_s1_q;
      rst_s1_q <= sys_reset;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  apv_cfg_if cfg_bus ();
  logic [APV_PW-1:0] scan_q;
  assign cfg_bus.rd_pt = scan_q;
  apv_cfg_mem u_mem (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wr_en(cfg_wr), .wr_pt(cfg_pt),
    .wr_func(cfg_func), .wr_zone(cfg_zone), .wr_open_alarm(cfg_open_alarm),
    .wr_verify(cfg_verify), .wr_latch(cfg_latch), .cfg(cfg_bus.store)
  );

  logic [1:0] kind_q [APV_NFUNC];
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < APV_NFUNC; i++)
        kind_q[i] <= APV_KIND_FIRE;
    end
    else if (ce && func_wr)
      kind_q[func_idx] <= func_kind;
  end

  logic [APV_SW-1:0] rrr_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rrr_q <= APV_RRR_DEF_S;
    else if (ce && rrr_wr)
      rrr_q <= (rrr_secs < APV_RRR_MIN_S) ? APV_RRR_MIN_S :
               (rrr_secs > APV_RRR_MAX_S) ? APV_RRR_MAX_S : rrr_secs;
  end

  // ----------------------------------------------------------------
  // scan pipeline: point at scan_q, config arrives one cycle later
  // ----------------------------------------------------------------
  logic [APV_PW-1:0] pt_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      scan_q <= '0;
      pt_q <= '0;
    end
    else if (ce)
    begin
      scan_q <= scan_q + 3'h1;
      pt_q <= scan_q;
    end
  end

  function automatic logic [1:0] loop_of(input logic [2*APV_NPTS-1:0] v,
                                         input logic [APV_PW-1:0] p);
    loop_of = v[2*p +: 2];
  endfunction

  logic [1:0] cur_loop;
  logic cur_kind_fire, cur_active, cur_open_tr, cur_can_verify;
  always_comb
  begin
    cur_loop = loop_of(loop_s2_q, pt_q);
    cur_kind_fire = (kind_q[cfg_bus.rd_func] == APV_KIND_FIRE);
    // short always alarm, open per point
    cur_active = (cur_loop == APV_LOOP_SHORT) || (cur_loop == APV_LOOP_ACTIVE) ||
                 (cur_loop == APV_LOOP_OPEN && cfg_bus.rd_open_alarm);
    cur_open_tr = (cur_loop == APV_LOOP_OPEN) && !cfg_bus.rd_open_alarm;
    cur_can_verify = cfg_bus.rd_verify && cur_kind_fire &&
                     (pt_addressable[pt_q] ||
                      (pt_two_wire[pt_q] && pt_q < 3'(APV_ONBOARD)) ||
                      (pt_q == 3'h0 && !pt_two_wire[pt_q]));
  end

  // ----------------------------------------------------------------
  // verification sequencer, one for the system
  // ----------------------------------------------------------------
  apv_vstate_e vst_q;
  logic [APV_PW-1:0] vpt_q;
  logic [6:0] vsec_q;
  logic [31:0] sup_q;
  logic tick;
  logic start_v, second_v, confirm_end;
  apv_sec_tick #(.CYC_PER_S(CYC_PER_S)) u_tick (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .clr(start_v), .tick(tick)
  );

  always_comb
  begin
    start_v = (vst_q == APV_IDLE) && cur_active && cur_can_verify && !pt_alarm[pt_q];
    second_v = (vst_q == APV_CONFIRM) && cur_active && (pt_q == vpt_q);
    confirm_end = (vst_q == APV_CONFIRM) && tick && (vsec_q == APV_CONFIRM_S - 7'h1);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      vst_q <= APV_IDLE;
      vpt_q <= '0;
      vsec_q <= '0;
    end
    else if (ce)
    begin
      unique case (vst_q)
        APV_IDLE:
        begin
          if (start_v)
          begin
            vst_q <= APV_RRR;
            vpt_q <= pt_q;
            vsec_q <= '0;
          end
        end
        APV_RRR:
        begin
          if (rst_s2_q)
            vst_q <= APV_IDLE;
          else if (tick)
          begin
            if (vsec_q == {2'h0, rrr_q} - 7'h1)
            begin
              vst_q <= APV_CONFIRM;
              vsec_q <= '0;
            end
            else
              vsec_q <= vsec_q + 7'h1;
          end
        end
        APV_CONFIRM:
        begin
          if (second_v || confirm_end || rst_s2_q)
            vst_q <= APV_IDLE;
          else if (tick)
            vsec_q <= vsec_q + 7'h1;
        end
        default: vst_q <= APV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sup_q <= '0;
      slc_reset_cmd <= '0;
      detector_supply_output_off <= 1'b0;
    end
    else if (ce)
    begin
      slc_reset_cmd <= '0;
      if (start_v)
      begin
        if (pt_addressable[pt_q])
          slc_reset_cmd[pt_q] <= 1'b1;
        else
        begin
          sup_q <= SUP_CYC;
          detector_supply_output_off <= 1'b1;
        end
      end
      else if (sup_q != 32'h0)
        sup_q <= sup_q - 32'h1;
      else
        detector_supply_output_off <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // point status and annunciation
  // ----------------------------------------------------------------
  logic in_verify;
  assign in_verify = (vst_q != APV_IDLE);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pt_alarm <= '0;
      pt_trouble <= '0;
      alarm_zone <= '0;
      alarm_zone_vld <= 1'b0;
    end
    else if (ce)
    begin
      alarm_zone_vld <= 1'b0;
      pt_trouble[pt_q] <= cur_open_tr;
      if (rst_s2_q)
        pt_alarm <= '0;
      else if (cur_active && !pt_alarm[pt_q] && !start_v &&
               !(in_verify && pt_q == vpt_q && !second_v))
      begin
        pt_alarm[pt_q] <= 1'b1;
        alarm_zone <= cfg_bus.rd_zone;
        alarm_zone_vld <= 1'b1;
      end
      else if (!cur_active && cur_loop == APV_LOOP_NORMAL && !cfg_bus.rd_latch)
        pt_alarm[pt_q] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      zone59_active <= 1'b0;
      zone59_num <= '0;
      verify_busy <= 1'b0;
      rrr_secs_q_out <= APV_RRR_DEF_S;
    end
    else if (ce)
    begin
      zone59_active <= in_verify || start_v;
      zone59_num <= APV_VERIF_ZONE;
      verify_busy <= in_verify || start_v;
      rrr_secs_q_out <= rrr_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_SHORT_ALARMS: assert property (ce && cur_loop == APV_LOOP_SHORT && !start_v && !in_verify && !rst_s2_q |=> pt_alarm[$past(pt_q)]) else $error("short loop did not alarm");
  AST_OPEN_TROUBLE: assert property (ce && cur_open_tr |=> pt_trouble[$past(pt_q)]) else $error("open loop trouble missing");
  AST_HOLD_FIRST: assert property (ce && start_v |=> !pt_alarm[$past(pt_q)] && !alarm_zone_vld) else $error("first verified activation annunciated");
  AST_SLC_RESET: assert property (ce && start_v && pt_addressable[pt_q] |=> slc_reset_cmd[$past(pt_q)]) else $error("no reset command");
  AST_ZONE59: assert property (ce && in_verify |=> zone59_active && zone59_num == APV_VERIF_ZONE) else $error("zone 59 not active");
  AST_RRR_RANGE: assert property (rrr_q >= APV_RRR_MIN_S && rrr_q <= APV_RRR_MAX_S && rrr_q < 5'(APV_RRR_LIMIT_S)) else $error("retard period out of range");
  AST_ONE_TIMER: assert property (ce && in_verify && !start_v |=> $stable(vpt_q)) else $error("verified point changed mid cycle");
  AST_OTHER_IMMEDIATE: assert property (ce && in_verify && cur_active && pt_q != vpt_q && !pt_alarm[pt_q] && !rst_s2_q |=> pt_alarm[$past(pt_q)]) else $error("other alarm delayed");
  AST_LATCH_HOLDS: assert property (ce && pt_alarm[pt_q] && cfg_bus.rd_latch && !rst_s2_q |=> pt_alarm[$past(pt_q)]) else $error("latched alarm cleared");
  AST_CONFIRM_END: assert property (ce && confirm_end && !second_v |=> vst_q == APV_IDLE) else $error("confirm end not dropped");
  AST_SUPPLY_DROP: assert property (ce && start_v && !pt_addressable[pt_q] |=> detector_supply_output_off) else $error("supply not dropped");

  COV_START: cover property (ce && start_v);
  COV_SECOND: cover property (ce && second_v);
  COV_TIMEOUT: cover property (ce && confirm_end);
  COV_SUPPLY: cover property (ce && start_v && !pt_addressable[pt_q]);
  COV_OTHER: cover property (ce && in_verify && cur_active && pt_q != vpt_q && !pt_alarm[pt_q]);
endmodule
`default_nettype wire

// File: rtl/apv_pkg.sv
// package of constants for the alarm point verification block
// Operation
// - each point maps to one of 16 functions
// - shorted loop always means alarm
// - per point open loop: alarm or trouble
// - per point output zone 01 to 50
// - first verified activation held from annunciation
// - reset point, alarm only on second activation
// - verify delay is the retard period, with the one second supply reset inside it
// - verify only fire smoke points, not others
// - verification enable kept per point
// - other alarms during cycle annunciate at once
// - one system wide verification timer
// - retard 6 to 21 s then 60 s confirm
// - retard period defaults to 11 seconds
// - addressable verified point gets reset command
// - zone 59 active during verification period
// - retard interval always below 30 seconds
// - verify only onboard four and addressable smokes
// - four smoke loops or one four wire loop
// - non latching alarm clears on standby, supply untouched
// - latching alarm holds until manual system reset
package apv_pkg;
  localparam int APV_NPTS = 8;
  localparam int APV_PW = 3;
  localparam int APV_NFUNC = 16;
  localparam int APV_FW = 4;
  localparam int APV_ZW = 6;
  localparam int APV_ZONE_MIN = 1;
  localparam int APV_ZONE_MAX = 50;
  localparam logic [5:0] APV_VERIF_ZONE = 6'h3b;
  localparam int APV_CLK_HZ = 40000000;
  localparam int APV_SW = 5;
  localparam logic [4:0] APV_RRR_MIN_S = 5'h06;
  localparam logic [4:0] APV_RRR_MAX_S = 5'h15;
  localparam logic [4:0] APV_RRR_DEF_S = 5'h0b;
  localparam int APV_RRR_LIMIT_S = 30;
  localparam logic [6:0] APV_CONFIRM_S = 7'h3c;
  localparam int APV_SUPPLY_RST_S = 1;
  localparam int APV_SUPPLY_RST_CYC = APV_SUPPLY_RST_S * APV_CLK_HZ;
  localparam int APV_ONBOARD = 4;
  // loop states
  localparam logic [1:0] APV_LOOP_NORMAL = 2'h0;
  localparam logic [1:0] APV_LOOP_OPEN = 2'h1;
  localparam logic [1:0] APV_LOOP_SHORT = 2'h2;
  localparam logic [1:0] APV_LOOP_ACTIVE = 2'h3;
  // function kinds
  localparam logic [1:0] APV_KIND_FIRE = 2'h0;
  localparam logic [1:0] APV_KIND_WATER = 2'h1;
  localparam logic [1:0] APV_KIND_SUPV = 2'h2;
  localparam logic [1:0] APV_KIND_OTHER = 2'h3;
  typedef enum logic [1:0] {APV_IDLE, APV_RRR, APV_CONFIRM} apv_vstate_e;
endpackage

// File: rtl/apv_cfg_if.sv
// interface carrying per point configuration lookups
`timescale 1ns/1ps
`default_nettype none
interface apv_cfg_if;
  import apv_pkg::*;
  logic [APV_PW-1:0] rd_pt;
  logic [APV_FW-1:0] rd_func;
  logic [APV_ZW-1:0] rd_zone;
  logic rd_open_alarm;
  logic rd_verify;
  logic rd_latch;
  modport store (input rd_pt, output rd_func, rd_zone, rd_open_alarm, rd_verify, rd_latch);
  modport user (output rd_pt, input rd_func, rd_zone, rd_open_alarm, rd_verify, rd_latch);
endinterface
`default_nettype wire

// File: rtl/apv_cfg_mem.sv
// per point configuration memory with registered read
`timescale 1ns/1ps
`default_nettype none
module apv_cfg_mem
  import apv_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [APV_PW-1:0] wr_pt,
  input wire logic [APV_FW-1:0] wr_func,
  input wire logic [APV_ZW-1:0] wr_zone,
  input wire logic wr_open_alarm,
  input wire logic wr_verify,
  input wire logic wr_latch,
  apv_cfg_if.store cfg
);
  localparam int W = APV_FW + APV_ZW + 3;
  logic [W-1:0] mem_q [APV_NPTS];
  logic [W-1:0] rd_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < APV_NPTS; i++)
        mem_q[i] <= {4'h9, 6'h01, 1'b0, 1'b0, 1'b1};
    end
    else if (ce && wr_en)
    begin
      mem_q[wr_pt] <= {wr_func,
        (wr_zone < 6'(APV_ZONE_MIN) || wr_zone > 6'(APV_ZONE_MAX)) ? 6'h01 : wr_zone,
        wr_open_alarm, wr_verify, wr_latch};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rd_q <= '0;
    else if (ce)
      rd_q <= mem_q[cfg.rd_pt];
  end

  assign {cfg.rd_func, cfg.rd_zone, cfg.rd_open_alarm, cfg.rd_verify, cfg.rd_latch} = rd_q;
endmodule
`default_nettype wire

// File: rtl/apv_sec_tick.sv
// one second tick generator
`timescale 1ns/1ps
`default_nettype none
module apv_sec_tick
  import apv_pkg::*;
#(
  parameter int CYC_PER_S = APV_CLK_HZ
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic clr,
  output logic tick
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      if (clr)
        cnt_q <= '0;
      else if (cnt_q == 32'(CYC_PER_S - 1))
      begin
        cnt_q <= '0;
        tick <= 1'b1;
      end
      else
        cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// File: tb/apv_loop_model.sv
// loop and detector model driving the point inputs
`timescale 1ns/1ps
`default_nettype none
module apv_loop_model
  import apv_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [APV_NPTS-1:0] slc_reset_cmd,
  input wire logic detector_supply_output_off,
  output logic [2*APV_NPTS-1:0] loop_state
);
  logic [2*APV_NPTS-1:0] lvl = '0;
  assign loop_state = lvl;
  // ------------------------------
  // stimulus hook
  // ------------------------------
  task automatic put(input int p, input logic [1:0] s);
    lvl[2*p +: 2] <= s;
  endtask
  // ------------------------------
  // detector reset response
  // ------------------------------
  // detector clears on reset
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < APV_NPTS; i++)
    begin
      if ((slc_reset_cmd[i] || detector_supply_output_off) && lvl[2*i +: 2] == APV_LOOP_ACTIVE)
        lvl[2*i +: 2] <= APV_LOOP_NORMAL;
    end
  end
endmodule
`default_nettype wire

// File: tb/alarm_point_verification_bench.sv
// self-checking bench for the alarm point verification block
`timescale 1ns/1ps
`default_nettype none
module alarm_point_verification_bench;
  import apv_pkg::*;
  localparam int CPS = 10;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic cfg_wr = 1'b0;
  logic [APV_PW-1:0] cfg_pt = '0;
  logic [APV_FW-1:0] cfg_func = '0;
  logic [APV_ZW-1:0] cfg_zone = '0;
  logic cfg_open_alarm = 1'b0;
  logic cfg_verify = 1'b0;
  logic cfg_latch = 1'b0;
  logic func_wr = 1'b0;
  logic [APV_FW-1:0] func_idx = '0;
  logic [1:0] func_kind = '0;
  logic [APV_NPTS-1:0] pt_addressable = 8'h01;
  logic [APV_NPTS-1:0] pt_two_wire = 8'h08;
  logic rrr_wr = 1'b0;
  logic [APV_SW-1:0] rrr_secs = '0;
  logic sys_reset = 1'b0;
  logic [2*APV_NPTS-1:0] loop_state;
  logic [APV_NPTS-1:0] pt_alarm, pt_trouble, slc_reset_cmd, seen_rst;
  logic [APV_ZW-1:0] alarm_zone, zone59_num, last_zone;
  logic alarm_zone_vld, detector_supply_output_off, zone59_active, verify_busy;
  logic [APV_SW-1:0] rrr_secs_q_out;
  int miscompares = 0;
  int checked = 0;
  int n;
  always #12.5 clk_sys = ~clk_sys;
  apv_top #(.CYC_PER_S(CPS)) u_apv_top (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .cfg_wr(cfg_wr), .cfg_pt(cfg_pt), .cfg_func(cfg_func), .cfg_zone(cfg_zone),
    .cfg_open_alarm(cfg_open_alarm), .cfg_verify(cfg_verify), .cfg_latch(cfg_latch),
    .func_wr(func_wr), .func_idx(func_idx), .func_kind(func_kind),
    .pt_addressable(pt_addressable), .pt_two_wire(pt_two_wire), .rrr_wr(rrr_wr),
    .rrr_secs(rrr_secs), .loop_state(loop_state), .sys_reset(sys_reset),
    .pt_alarm(pt_alarm), .pt_trouble(pt_trouble), .alarm_zone(alarm_zone),
    .alarm_zone_vld(alarm_zone_vld), .slc_reset_cmd(slc_reset_cmd),
    .detector_supply_output_off(detector_supply_output_off),
    .zone59_active(zone59_active), .zone59_num(zone59_num),
    .verify_busy(verify_busy), .rrr_secs_q_out(rrr_secs_q_out));
  apv_loop_model u_apv_loop_model (.clk_sys(clk_sys), .slc_reset_cmd(slc_reset_cmd),
    .detector_supply_output_off(detector_supply_output_off), .loop_state(loop_state));
  // ------------------------------
  // monitors
  // ------------------------------
  initial seen_rst <= '0;
  initial last_zone <= '0;
  always @(posedge clk_sys)
  begin
    if (alarm_zone_vld)
      last_zone <= alarm_zone;
    seen_rst <= seen_rst | slc_reset_cmd;
  end
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic wr_pt(input int p, input int f, input int z, input logic o, input logic v,
    input logic l);
    cfg_pt = p[APV_PW-1:0];
    cfg_func = f[APV_FW-1:0];
    cfg_zone = z[APV_ZW-1:0];
    cfg_open_alarm = o;
    cfg_verify = v;
    cfg_latch = l;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
  endtask
  task automatic wr_rrr(input int s);
    rrr_secs = s[APV_SW-1:0];
    rrr_wr = 1'b1;
    cyc(1);
    rrr_wr = 1'b0;
    cyc(2);
  endtask
  task automatic wait_al(input int p);
    repeat (20) if (pt_alarm[p] !== 1'b1) cyc(1);
    cyc(1);
  endtask
  task automatic wait_busy();
    repeat (20) if (verify_busy !== 1'b1) cyc(1);
  endtask
  task automatic clear_all();
    for (int i = 0; i < APV_NPTS; i++)
      u_apv_loop_model.put(i, APV_LOOP_NORMAL);
    cyc(20);
    sys_reset = 1'b1;
    cyc(4);
    sys_reset = 1'b0;
    cyc(10);
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    chk(rrr_secs_q_out, 11, "retard default");
    chk(pt_alarm, 0, "alarms after reset");
    chk(verify_busy, 0, "busy after reset");
    $display("done reset");
  endtask
  task automatic t_loops();
    wr_pt(1, 0, 7, 1'b0, 1'b0, 1'b0);
    wr_pt(2, 0, 60, 1'b1, 1'b0, 1'b1);
    u_apv_loop_model.put(1, APV_LOOP_OPEN);
    cyc(20);
    chk(pt_trouble[1], 1, "open as trouble");
    chk(pt_alarm[1], 0, "open not alarm");
    u_apv_loop_model.put(1, APV_LOOP_SHORT);
    wait_al(1);
    chk(pt_alarm[1], 1, "short alarms");
    chk(last_zone, 7, "zone of point");
    u_apv_loop_model.put(1, APV_LOOP_NORMAL);
    cyc(20);
    chk(pt_alarm[1], 0, "restore clears");
    u_apv_loop_model.put(2, APV_LOOP_OPEN);
    wait_al(2);
    chk(pt_alarm[2], 1, "open as alarm");
    chk(last_zone, 1, "zone out of range");
    u_apv_loop_model.put(2, APV_LOOP_NORMAL);
    cyc(20);
    chk(pt_alarm[2], 1, "latched holds");
    clear_all();
    chk(pt_alarm[2], 0, "manual reset clears");
    $display("done loops");
  endtask
  task automatic t_confirm();
    wr_pt(0, 0, 5, 1'b0, 1'b1, 1'b1);
    wr_pt(3, 0, 9, 1'b0, 1'b1, 1'b0);
    seen_rst <= '0;
    u_apv_loop_model.put(0, APV_LOOP_ACTIVE);
    wait_busy();
    chk(verify_busy, 1, "verify started");
    chk(pt_alarm[0], 0, "first held off");
    chk(zone59_active, 1, "zone 59 on");
    chk(zone59_num, 8'h3b, "zone 59 number");
    cyc(4);
    chk(seen_rst[0], 1, "reset command");
    u_apv_loop_model.put(3, APV_LOOP_ACTIVE);
    wait_al(3);
    chk(pt_alarm[3], 1, "other immediate");
    chk(verify_busy, 1, "one timer");
    cyc(11 * CPS + 25);
    chk(verify_busy, 1, "in confirm");
    chk(pt_alarm[0], 0, "still held");
    u_apv_loop_model.put(0, APV_LOOP_ACTIVE);
    wait_al(0);
    chk(pt_alarm[0], 1, "second alarms");
    chk(last_zone, 5, "verified zone");
    cyc(2);
    chk(verify_busy, 0, "verify done");
    clear_all();
    $display("done confirm");
  endtask
  task automatic t_drop();
    wr_rrr(3);
    chk(rrr_secs_q_out, 6, "clamp low");
    seen_rst <= '0;
    u_apv_loop_model.put(3, APV_LOOP_ACTIVE);
    wait_busy();
    chk(detector_supply_output_off, 1, "supply dropped");
    n = 0;
    while (verify_busy === 1'b1 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    chk(n >= 66 * CPS - 15 && n <= 66 * CPS + 20, 1, "retard plus confirm");
    chk(pt_alarm[3], 0, "event dropped");
    chk(detector_supply_output_off, 0, "supply back");
    chk(seen_rst, 0, "no command for wired point");
    chk(zone59_active, 0, "zone 59 off");
    wr_rrr(25);
    chk(rrr_secs_q_out, 21, "clamp high");
    wr_rrr(11);
    $display("done drop");
  endtask
  task automatic t_inelig();
    func_idx = 4'h2;
    func_kind = APV_KIND_WATER;
    func_wr = 1'b1;
    cyc(1);
    func_wr = 1'b0;
    pt_addressable[4] = 1'b1;
    pt_two_wire[5] = 1'b1;
    wr_pt(4, 2, 3, 1'b0, 1'b1, 1'b1);
    wr_pt(5, 0, 3, 1'b0, 1'b1, 1'b1);
    for (int p = 4; p < 6; p++)
    begin
      u_apv_loop_model.put(p, APV_LOOP_ACTIVE);
      wait_al(p);
      chk(pt_alarm[p], 1, "no verify alarm");
      chk(verify_busy, 0, "no verify cycle");
      clear_all();
    end
    $display("done ineligible");
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    cyc(10);
    rstn = 1'b1;
    cyc(2);
    t_reset();
    t_loops();
    t_confirm();
    t_drop();
    t_inelig();
    close_out();
  end
  initial
  begin
    #(6000 * 25);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
